// [hw/ssp_sched_tx.v]
// ssp_sched_tx: frame-driven sensor read schedule, scaling and transmit
// decision for five sensor slots (pulse, two analogue, two sdi-12)
// assumes frame_tick is a one-cycle pulse and tip_pulse is debounced
//
// Behaviour
// - Each enabled sensor is read once per read period in frames, then judged for sending.
// - Transmit period is a whole multiple of the read period; zero turns periodic sends off.
// - Reads and periodic sends both fall on frame counts congruent to the offset.
// - A change from the last sent value of at least a non-zero threshold sends.
// - With event mode on, every value above the event threshold sends.
// - Finished value is raw times slope plus calibration and physical offsets.
// - The pulse slot adds one increment value per switch closure instead of scaling.
// - Analogue inputs one and two each select voltage or current-loop measurement.
// - Sdi-12 sensors sit on bus a or b and the two buses measure at the same time.
// - A sensor address is one letter of either case or one decimal digit.
// - Measurement commands of the m, c and r kinds are issued.
// - The value used is the one at a one-based index in the returned list.
// - After m or c the device waits the duration, or a self-learned one, before collecting.
// - Disabled sensors are neither read nor sent.
`timescale 1ns/1ps
`include "ssp_map.vh"
module ssp_sched_tx #(
  parameter integer MS_CYC = `SSP_MS_CYC
) (
  input wire ref_clk,
  input wire arst_n,
  input wire frame_tick,
  input wire [6:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire tip_pulse,
  output reg adc_start,
  output reg adc_chan,
  output reg adc_sel_ma,
  input wire adc_done,
  input wire [15:0] adc_data,
  output wire [1:0] sdi_cmd_vld,
  output wire [15:0] sdi_cmd_addr,
  output wire [15:0] sdi_cmd_char,
  input wire [1:0] sdi_resp_vld,
  input wire [31:0] sdi_resp_ttt,
  input wire [1:0] sdi_val_vld,
  input wire [63:0] sdi_val_data,
  input wire [1:0] sdi_val_last,
  output reg tx_req,
  output reg [2:0] tx_slot,
  output reg [31:0] tx_value
);
  // ==========================================================
  // configuration and state
  reg [15:0] ctrl [0:4];
  reg [15:0] rdper [0:4];
  reg [15:0] txper [0:4];
  reg [15:0] offs [0:4];
  reg [31:0] chthr [0:4];
  reg [31:0] evthr [0:4];
  reg [31:0] slope [0:4];
  reg [31:0] caloff [0:4];
  reg [31:0] phyoff [0:4];
  reg [11:0] sdicmd [0:4];
  reg [15:0] dur [0:4];
  reg [31:0] lmeas [0:4];
  reg [31:0] ltx [0:4];
  reg [31:0] res_raw [0:4];
  reg [15:0] frame;
  reg tick_d;
  reg [31:0] acc;
  reg [4:0] pend;
  reg [4:0] ptx;
  reg [4:0] res_vld;
  reg [4:0] clr;
  wire [4:0] rd_hit;
  wire [4:0] tx_hit;
  reg adc_busy;
  wire adc_go = !adc_busy && (pend[1] || pend[2]);
  wire [1:0] sdi_busy;
  wire [1:0] sdi_go;
  wire [1:0] sdi_use4;
  reg [1:0] eng4;
  wire [1:0] sdi_done;
  wire [63:0] sdi_value;
  wire [1:0] learn_vld;
  wire [31:0] learn_ms;
  reg pick_vld;
  reg [2:0] pick_slot;
  reg fin_vld;
  reg [2:0] fin_slot;
  reg [31:0] fin_val;
  reg fin_ptx;
  reg [31:0] rmux;
  integer i;
  wire [2:0] ws = reg_addr[6:4];
  wire [3:0] wf = reg_addr[3:0];
  wire slot_ok = (ws < `SSP_NSLOT);
  wire [31:0] diff = fin_val - ltx[fin_slot];
  wire [31:0] absd = diff[31] ? (32'h00000000 - diff) : diff;
  wire [15:0] fctl = ctrl[fin_slot];
  wire chg = (chthr[fin_slot] != 32'h00000000) && (absd >= chthr[fin_slot]);
  wire evt = fctl[`SSP_B_EVT] && ($signed(fin_val) > $signed(evthr[fin_slot]));
  wire send = fctl[`SSP_B_EN] && (fin_ptx || chg || evt);

  // ==========================================================
  // decoding helpers
  function sched_hit;
    input [15:0] cnt;
    input [15:0] per;
    input [15:0] off;
    begin
      sched_hit = (per != 16'h0000) && ((cnt % per) == (off % per));
    end
  endfunction

  function addr_ok;
    input [7:0] c;
    begin
      addr_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5A) ||
        (c >= 8'h61 && c <= 8'h7A);
    end
  endfunction

  function cmd_ok;
    input [7:0] c;
    begin
      cmd_ok = (c == `SSP_CH_M) || (c == `SSP_CH_C) || (c == `SSP_CH_R);
    end
  endfunction

  // ==========================================================
  // frame counter; schedules look at the count one cycle after the tick
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frame <= 16'h0000;
      tick_d <= 1'b0;
    end else begin
      tick_d <= frame_tick;
      if (frame_tick) begin
        frame <= frame + 16'h0001;
      end
    end
  end

  // per-slot schedule; a send is only judged on frames that also read
  genvar s;
  generate
    for (s = 0; s < 5; s = s + 1) begin : g_sched
      wire [15:0] c = ctrl[s];
      assign rd_hit[s] = tick_d && c[`SSP_B_EN] && sched_hit(frame, rdper[s], offs[s]);
      assign tx_hit[s] = sched_hit(frame, txper[s], offs[s]);
    end
  endgenerate

  // ==========================================================
  // read requests: a new schedule hit wins over a same-cycle clear
  always @* begin
    clr = 5'h00;
    clr[0] = pend[0];
    if (adc_go) begin
      clr[1] = pend[1];
      clr[2] = !pend[1];
    end
    for (i = 0; i < 2; i = i + 1) begin
      if (sdi_go[i]) begin
        clr[3] = clr[3] | !sdi_use4[i];
        clr[4] = clr[4] | sdi_use4[i];
      end
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 5'h00;
      ptx <= 5'h00;
    end else begin
      pend <= (pend & ~clr) | rd_hit;
      ptx <= (ptx & ~rd_hit) | (rd_hit & tx_hit);
    end
  end

  // ==========================================================
  // analogue conversion: one converter, inputs taken in turn
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_busy <= 1'b0;
      adc_start <= 1'b0;
      adc_chan <= 1'b0;
      adc_sel_ma <= 1'b0;
    end else begin
      adc_start <= adc_go;
      if (adc_go) begin
        adc_busy <= 1'b1;
        adc_chan <= !pend[1];
        adc_sel_ma <= pend[1] ? ctrl[1][`SSP_B_MA] : ctrl[2][`SSP_B_MA];
      end else if (adc_done) begin
        adc_busy <= 1'b0;
      end
    end
  end

  // ==========================================================
  // sdi-12 buses: one sequencer each so both run side by side
  wire [1:0] on3 = ctrl[3][`SSP_B_BUS] ? 2'b10 : 2'b01;
  wire [1:0] on4 = ctrl[4][`SSP_B_BUS] ? 2'b10 : 2'b01;
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bus
      wire sel3 = pend[3] && on3[b];
      wire sel4 = pend[4] && on4[b];
      wire [2:0] gs = sel3 ? `SSP_SL_SDI1 : `SSP_SL_SDI2;
      wire [15:0] gc = ctrl[gs];
      wire [11:0] gm = sdicmd[gs];
      assign sdi_go[b] = !sdi_busy[b] && (sel3 || sel4);
      assign sdi_use4[b] = !sel3;
      always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          eng4[b] <= 1'b0;
        end else if (sdi_go[b]) begin
          eng4[b] <= !sel3;
        end
      end
      ssp_sdi_eng #(.MS_CYC(MS_CYC)) u_eng (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .start(sdi_go[b]),
        .sens_addr(gc[15:8]),
        .cmd_code(gm[7:0]),
        .val_index(gm[11:8]),
        .dur_ms(dur[gs]),
        .auto_adj(gc[`SSP_B_AUTO]),
        .cmd_vld(sdi_cmd_vld[b]),
        .cmd_addr(sdi_cmd_addr[8*b+7:8*b]),
        .cmd_char(sdi_cmd_char[8*b+7:8*b]),
        .resp_vld(sdi_resp_vld[b]),
        .resp_ttt(sdi_resp_ttt[16*b+15:16*b]),
        .val_vld(sdi_val_vld[b]),
        .val_data(sdi_val_data[32*b+31:32*b]),
        .val_last(sdi_val_last[b]),
        .busy(sdi_busy[b]),
        .done(sdi_done[b]),
        .value(sdi_value[32*b+31:32*b]),
        .learn_vld(learn_vld[b]),
        .learn_ms(learn_ms[16*b+15:16*b])
      );
    end
  endgenerate

  // ==========================================================
  // tipping-bucket accumulator; software may preset it
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= 32'h00000000;
    end else if (reg_wr && ws == `SSP_SL_PULSE && wf == `SSP_F_LMEAS) begin
      acc <= reg_wdata;
    end else if (tip_pulse && ctrl[0][`SSP_B_EN]) begin
      acc <= acc + phyoff[0];
    end
  end

  // ==========================================================
  // raw results wait here until the scaling stage takes them
  always @* begin
    pick_vld = 1'b0;
    pick_slot = 3'h0;
    for (i = 4; i >= 0; i = i - 1) begin
      if (res_vld[i]) begin
        pick_vld = 1'b1;
        pick_slot = i[2:0];
      end
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      res_vld <= 5'h00;
      for (i = 0; i < 5; i = i + 1) begin
        res_raw[i] <= 32'h00000000;
      end
    end else begin
      if (pick_vld) begin
        res_vld[pick_slot] <= 1'b0;
      end
      if (pend[0]) begin
        res_vld[0] <= 1'b1;
        res_raw[0] <= acc;
      end
      // converter result already in millivolts or microamps
      if (adc_busy && adc_done) begin
        res_vld[{2'h0, adc_chan} + 3'h1] <= 1'b1;
        res_raw[{2'h0, adc_chan} + 3'h1] <= {16'h0000, adc_data};
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (sdi_done[i]) begin
          res_vld[3 + eng4[i]] <= 1'b1;
          res_raw[3 + eng4[i]] <= sdi_value[32*i +: 32];
        end
      end
    end
  end

  // ==========================================================
  // scaling then send decision, one slot per cycle
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fin_vld <= 1'b0;
      fin_slot <= 3'h0;
      fin_val <= 32'h00000000;
      fin_ptx <= 1'b0;
      tx_req <= 1'b0;
      tx_slot <= 3'h0;
      tx_value <= 32'h00000000;
      for (i = 0; i < 5; i = i + 1) begin
        lmeas[i] <= 32'h00000000;
        ltx[i] <= 32'h00000000;
      end
    end else begin
      fin_vld <= pick_vld;
      if (pick_vld) begin
        fin_slot <= pick_slot;
        fin_ptx <= ptx[pick_slot];
        // low word of the product is the same signed or unsigned
        fin_val <= (pick_slot == `SSP_SL_PULSE) ? res_raw[0] :
          res_raw[pick_slot] * slope[pick_slot] + caloff[pick_slot] +
          phyoff[pick_slot];
      end
      tx_req <= fin_vld && send;
      if (fin_vld) begin
        lmeas[fin_slot] <= fin_val;
        if (send) begin
          tx_slot <= fin_slot;
          tx_value <= fin_val;
          ltx[fin_slot] <= fin_val;
        end
      end
    end
  end

  // ==========================================================
  // register writes; bad addresses, commands or index 0 are dropped
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 5; i = i + 1) begin
        ctrl[i] <= {`SSP_RST_ADDR, 8'h00};
        rdper[i] <= 16'h0000;
        txper[i] <= 16'h0000;
        offs[i] <= 16'h0000;
        chthr[i] <= 32'h00000000;
        evthr[i] <= 32'h00000000;
        slope[i] <= `SSP_RST_SLOPE;
        caloff[i] <= 32'h00000000;
        phyoff[i] <= 32'h00000000;
        sdicmd[i] <= `SSP_RST_SDICMD;
        dur[i] <= `SSP_RST_DUR;
      end
    end else begin
      if (reg_wr && slot_ok) begin
        if (wf == `SSP_F_CTRL) begin
          ctrl[ws] <= {addr_ok(reg_wdata[15:8]) ? reg_wdata[15:8] : ctrl[ws][15:8],
            3'h0, reg_wdata[4:0]};
        end else if (wf == `SSP_F_RDPER) begin
          rdper[ws] <= reg_wdata[15:0];
        end else if (wf == `SSP_F_TXPER) begin
          txper[ws] <= reg_wdata[15:0];
        end else if (wf == `SSP_F_OFFS) begin
          offs[ws] <= reg_wdata[15:0];
        end else if (wf == `SSP_F_CHTHR) begin
          chthr[ws] <= reg_wdata;
        end else if (wf == `SSP_F_EVTHR) begin
          evthr[ws] <= reg_wdata;
        end else if (wf == `SSP_F_SLOPE) begin
          slope[ws] <= reg_wdata;
        end else if (wf == `SSP_F_CALOFF) begin
          caloff[ws] <= reg_wdata;
        end else if (wf == `SSP_F_PHYOFF) begin
          phyoff[ws] <= reg_wdata;
        end else if (wf == `SSP_F_SDICMD) begin
          if (cmd_ok(reg_wdata[7:0]) && reg_wdata[11:8] != 4'h0) begin
            sdicmd[ws] <= reg_wdata[11:0];
          end
        end else if (wf == `SSP_F_DUR) begin
          dur[ws] <= reg_wdata[15:0];
        end
      end
      // a learned duration overrides a same-cycle software write
      for (i = 0; i < 2; i = i + 1) begin
        if (learn_vld[i]) begin
          dur[3 + eng4[i]] <= learn_ms[16*i +: 16];
        end
      end
    end
  end

  // ==========================================================
  // register reads: data stand for the one cycle after the strobe
  always @* begin
    rmux = 32'h00000000;
    if (ws == `SSP_SL_GLOB && wf == `SSP_F_FRAME) begin
      rmux = {16'h0000, frame};
    end else if (ws == `SSP_SL_GLOB && wf == `SSP_F_STAT) begin
      rmux = {19'h00000, adc_busy, sdi_busy, res_vld, pend};
    end else if (slot_ok) begin
      if (wf == `SSP_F_CTRL) begin
        rmux = {16'h0000, ctrl[ws]};
      end else if (wf == `SSP_F_RDPER) begin
        rmux = {16'h0000, rdper[ws]};
      end else if (wf == `SSP_F_TXPER) begin
        rmux = {16'h0000, txper[ws]};
      end else if (wf == `SSP_F_OFFS) begin
        rmux = {16'h0000, offs[ws]};
      end else if (wf == `SSP_F_CHTHR) begin
        rmux = chthr[ws];
      end else if (wf == `SSP_F_EVTHR) begin
        rmux = evthr[ws];
      end else if (wf == `SSP_F_SLOPE) begin
        rmux = slope[ws];
      end else if (wf == `SSP_F_CALOFF) begin
        rmux = caloff[ws];
      end else if (wf == `SSP_F_PHYOFF) begin
        rmux = phyoff[ws];
      end else if (wf == `SSP_F_SDICMD) begin
        rmux = {20'h00000, sdicmd[ws]};
      end else if (wf == `SSP_F_DUR) begin
        rmux = {16'h0000, dur[ws]};
      end else if (wf == `SSP_F_LMEAS) begin
        rmux = (ws == `SSP_SL_PULSE) ? acc : lmeas[ws];
      end else if (wf == `SSP_F_LTX) begin
        rmux = ltx[ws];
      end
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= reg_rd ? rmux : 32'h00000000;
    end
  end
endmodule

// [inc/ssp_map.vh]
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
// ssp register map, field positions, reset values and timing counts
// assumes a word-indexed port: addr[6:4] picks a slot, addr[3:0] a field
`define SSP_NSLOT 3'h5
`define SSP_SL_PULSE 3'h0
`define SSP_SL_AN1 3'h1
`define SSP_SL_AN2 3'h2
`define SSP_SL_SDI1 3'h3
`define SSP_SL_SDI2 3'h4
`define SSP_SL_GLOB 3'h7
`define SSP_F_CTRL 4'h0
`define SSP_F_RDPER 4'h1
`define SSP_F_TXPER 4'h2
`define SSP_F_OFFS 4'h3
`define SSP_F_CHTHR 4'h4
`define SSP_F_EVTHR 4'h5
`define SSP_F_SLOPE 4'h6
`define SSP_F_CALOFF 4'h7
`define SSP_F_PHYOFF 4'h8
`define SSP_F_SDICMD 4'h9
`define SSP_F_DUR 4'hA
`define SSP_F_LMEAS 4'hB
`define SSP_F_LTX 4'hC
`define SSP_F_FRAME 4'h0
`define SSP_F_STAT 4'h1
`define SSP_B_EN 0
`define SSP_B_EVT 1
`define SSP_B_MA 2
`define SSP_B_BUS 3
`define SSP_B_AUTO 4
`define SSP_RST_SLOPE 32'h00000001
`define SSP_RST_SDICMD 12'h14D
`define SSP_RST_ADDR 8'h30
`define SSP_RST_DUR 16'h0000
`define SSP_CH_M 8'h4D
`define SSP_CH_C 8'h43
`define SSP_CH_R 8'h52
`define SSP_CH_D 8'h44
`define SSP_CLK_NS 10
`define SSP_MS_NS 1000000
`define SSP_MS_CYC (`SSP_MS_NS / `SSP_CLK_NS)
`define SSP_MS_PER_S 16'h03E8
`endif

// [hw/ssp_sdi_eng.v]
// ssp_sdi_eng: one sdi-12 bus measurement sequencer
// assumes a character-level transceiver outside that frames commands and
// hands back the attention time and the value list one value at a time
`timescale 1ns/1ps
`include "ssp_map.vh"
module ssp_sdi_eng #(
  parameter integer MS_CYC = `SSP_MS_CYC
) (
  input wire ref_clk,
  input wire arst_n,
  input wire start,
  input wire [7:0] sens_addr,
  input wire [7:0] cmd_code,
  input wire [3:0] val_index,
  input wire [15:0] dur_ms,
  input wire auto_adj,
  output reg cmd_vld,
  output reg [7:0] cmd_addr,
  output reg [7:0] cmd_char,
  input wire resp_vld,
  input wire [15:0] resp_ttt,
  input wire val_vld,
  input wire [31:0] val_data,
  input wire val_last,
  output wire busy,
  output reg done,
  output reg [31:0] value,
  output reg learn_vld,
  output reg [15:0] learn_ms
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ATTN = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_COLL = 3'h3;
  localparam [19:0] MS_LAST = MS_CYC[19:0] - 20'h00001;
  reg [2:0] state;
  reg [3:0] idx;
  reg [3:0] pos;
  reg [15:0] dur;
  reg auto;
  reg [15:0] wait_ms;
  reg [15:0] ms_cnt;
  reg [19:0] cyc_cnt;
  wire [31:0] ttt_ms = resp_ttt * `SSP_MS_PER_S;
  assign busy = (state != ST_IDLE);
  // ==========================================================
  // command, wait and collect sequence
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cmd_vld <= 1'b0;
      cmd_addr <= 8'h00;
      cmd_char <= 8'h00;
      done <= 1'b0;
      value <= 32'h00000000;
      learn_vld <= 1'b0;
      learn_ms <= 16'h0000;
      idx <= 4'h1;
      pos <= 4'h1;
      dur <= 16'h0000;
      auto <= 1'b0;
      wait_ms <= 16'h0000;
      ms_cnt <= 16'h0000;
      cyc_cnt <= 20'h00000;
    end else begin
      cmd_vld <= 1'b0;
      done <= 1'b0;
      learn_vld <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            cmd_vld <= 1'b1;
            cmd_addr <= sens_addr;
            cmd_char <= cmd_code;
            idx <= val_index;
            dur <= dur_ms;
            auto <= auto_adj;
            pos <= 4'h1;
            value <= 32'h00000000;
            // continuous reads hand back values with no wait
            state <= (cmd_code == `SSP_CH_R) ? ST_COLL : ST_ATTN;
          end
        end
        ST_ATTN: begin
          if (resp_vld) begin
            learn_vld <= auto;
            learn_ms <= ttt_ms[15:0];
            wait_ms <= auto ? ttt_ms[15:0] : dur;
            ms_cnt <= 16'h0000;
            cyc_cnt <= 20'h00000;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (ms_cnt == wait_ms) begin
            cmd_vld <= 1'b1;
            cmd_char <= `SSP_CH_D;
            state <= ST_COLL;
          end else if (cyc_cnt == MS_LAST) begin
            cyc_cnt <= 20'h00000;
            ms_cnt <= ms_cnt + 16'h0001;
          end else begin
            cyc_cnt <= cyc_cnt + 20'h00001;
          end
        end
        ST_COLL: begin
          if (val_vld) begin
            if (pos == idx) begin
              value <= val_data;
            end
            pos <= pos + 4'h1;
            if (val_last) begin
              done <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// [verif/ssp_sched_tx_checker.sv]
// checker for ssp_sched_tx: send pulses, adc and sdi strobes, frame reads
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module ssp_chk (
  input wire ref_clk,
  input wire arst_n,
  input wire frame_tick,
  input wire [6:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire adc_start,
  input wire adc_chan,
  input wire adc_sel_ma,
  input wire adc_done,
  input wire [1:0] sdi_cmd_vld,
  input wire [1:0] sdi_val_last,
  input wire tx_req,
  input wire [2:0] tx_slot
);
  reg [31:0] fcnt;
  reg [5:0] since;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ================
  // trackers; since saturates so an old cause never looks fresh
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fcnt <= 32'h0;
      since <= 6'h3F;
    end else begin
      fcnt <= fcnt + {31'h0, frame_tick};
      if (frame_tick | adc_done | (|sdi_val_last))
        since <= 6'h0;
      else if (since != 6'h3F)
        since <= since + 6'h1;
    end
  end
  frame_read_a: assert property (reg_rd && reg_addr == 7'h70 && !frame_tick
    |=> reg_rdata == $past(fcnt)) else $error("frame count read wrong");
  tx_pulse_a: assert property (tx_req |=> !(tx_req && tx_slot == $past(tx_slot)))
    else $error("send repeated for one slot");
  tx_slot_a: assert property (tx_req |-> tx_slot <= 3'h4) else $error("no such slot");
  tx_cause_a: assert property (tx_req |-> since <= 6'd20) else $error("no send cause");
  rst_quiet_a: assert property ($rose(arst_n) |-> !tx_req && !adc_start && !sdi_cmd_vld)
    else $error("output active after reset");
  adc_pulse_a: assert property (adc_start |=> !adc_start) else $error("adc start long");
  adc_hold_a: assert property (adc_start |=> $stable(adc_chan) && $stable(adc_sel_ma))
    else $error("adc select moved");
  sdi_pulse_a: assert property (sdi_cmd_vld[0] |=> !sdi_cmd_vld[0])
    else $error("sdi cmd long");
  cover property (tx_req && tx_slot == 3'h0);
  cover property (adc_start && adc_sel_ma);
  cover property (&sdi_cmd_vld);
endmodule
bind ssp_sched_tx ssp_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n), .frame_tick(frame_tick),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start(adc_start),
  .adc_chan(adc_chan), .adc_sel_ma(adc_sel_ma), .adc_done(adc_done), .sdi_cmd_vld(sdi_cmd_vld),
  .sdi_val_last(sdi_val_last), .tx_req(tx_req), .tx_slot(tx_slot));

// [verif/ssp_far_model.sv]
// far side: adc converter and one sdi-12 sensor on each bus
// assumes lat is at least one; raw codes mark channel and range
`timescale 1ns/1ps
module ssp_far_model (
  input wire ref_clk,
  input wire [3:0] lat,
  input wire adc_start,
  input wire adc_chan,
  input wire adc_sel_ma,
  output reg adc_done = 1'b0,
  output wire [15:0] adc_data,
  input wire [1:0] sdi_cmd_vld,
  input wire [15:0] sdi_cmd_addr,
  input wire [15:0] sdi_cmd_char,
  output wire [1:0] sdi_resp_vld,
  output wire [31:0] sdi_resp_ttt,
  output wire [1:0] sdi_val_vld,
  output wire [63:0] sdi_val_data,
  output wire [1:0] sdi_val_last
);
  reg [15:0] ad = 16'h0;
  reg [3:0] aw = 4'h0;
  genvar b;
  // ================
  // converter; data outside the done pulse shows the inverse so stale reads stand out
  always @(posedge ref_clk) begin
    adc_done <= 1'b0;
    if (adc_start) begin
      ad <= {14'h0040, adc_chan, adc_sel_ma};
      aw <= lat;
    end else if (aw != 4'h0) begin
      aw <= aw - 4'h1;
      adc_done <= aw == 4'h1;
    end
  end
  assign adc_data = adc_done ? ad : ~ad;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bus
      reg rv = 1'b0;
      reg vv = 1'b0;
      reg vl = 1'b0;
      reg [7:0] a = 8'h0;
      reg [2:0] t = 3'h0;
      reg [2:0] k = 3'h0;
      reg [31:0] vd = 32'h0;
      // attention two cycles after m or c, three values after d or r
      always @(posedge ref_clk) begin
        rv <= t == 3'h1;
        t <= (t == 3'h0) ? 3'h0 : t - 3'h1;
        vv <= k != 3'h0;
        vl <= k == 3'h3;
        vd <= {16'h0, a, 5'h0, k};
        if (sdi_cmd_vld[b]) begin
          a <= sdi_cmd_addr[8*b+:8];
          if (sdi_cmd_char[8*b+:8] == 8'h44 || sdi_cmd_char[8*b+:8] == 8'h52)
            k <= 3'h1;
          else
            t <= 3'h2;
        end else if (k != 3'h0)
          k <= (k == 3'h3) ? 3'h0 : k + 3'h1;
      end
      assign sdi_resp_vld[b] = rv;
      assign sdi_resp_ttt[16*b+:16] = 16'h0;
      assign sdi_val_vld[b] = vv;
      assign sdi_val_last[b] = vl;
      assign sdi_val_data[32*b+:32] = vv ? vd : ~vd;
    end
  endgenerate
endmodule

// [verif/ssp_sched_tx_tb_top.sv]
// bench for ssp_sched_tx: register setup, frames, pulse, adc and sdi sends
// assumes ssp_far_model answers adc and both sdi-12 buses
`timescale 1ns/1ps
module ssp_sched_tx_tb_top;
  reg ref_clk = 1'b0;
  reg arst_n = 1'b0;
  reg frame_tick = 1'b0;
  reg [6:0] reg_addr = 7'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg tip_pulse = 1'b0;
  reg [3:0] lat = 4'h1;
  wire [31:0] reg_rdata, tx_value, ttt;
  wire adc_start, adc_chan, adc_sel_ma, adc_done, tx_req;
  wire [15:0] adc_data, ca, cc;
  wire [1:0] cv, rv, vv, vl;
  wire [63:0] vd;
  wire [2:0] tx_slot;
  integer n_errors = 0, checked = 0;
  integer seed = 3;
  integer fr = 0, i, j;
  reg [31:0] d, e, p, sl;
  reg [31:0] got [0:7], cnt [0:7], at [0:7];
  ssp_sched_tx #(.MS_CYC(4)) uut (.ref_clk(ref_clk), .arst_n(arst_n), .frame_tick(frame_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tip_pulse(tip_pulse), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_sel_ma(adc_sel_ma), .adc_done(adc_done), .adc_data(adc_data), .sdi_cmd_vld(cv),
    .sdi_cmd_addr(ca), .sdi_cmd_char(cc), .sdi_resp_vld(rv), .sdi_resp_ttt(ttt),
    .sdi_val_vld(vv), .sdi_val_data(vd), .sdi_val_last(vl), .tx_req(tx_req),
    .tx_slot(tx_slot), .tx_value(tx_value));
  ssp_far_model fm (.ref_clk(ref_clk), .lat(lat), .adc_start(adc_start), .adc_chan(adc_chan),
    .adc_sel_ma(adc_sel_ma), .adc_done(adc_done), .adc_data(adc_data), .sdi_cmd_vld(cv),
    .sdi_cmd_addr(ca), .sdi_cmd_char(cc), .sdi_resp_vld(rv), .sdi_resp_ttt(ttt),
    .sdi_val_vld(vv), .sdi_val_data(vd), .sdi_val_last(vl));
  // ================
  // compare and count
  task chk(input [31:0] g, input [31:0] x);
    begin
      checked = checked + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task wr(input [6:0] a, input [31:0] v);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [6:0] a, output [31:0] v);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  // one frame, then a fixed window logging sends and their cycle
  task tick;
    begin
      for (i = 0; i < 8; i = i + 1) {cnt[i], got[i]} = 64'h0;
      @(posedge ref_clk);
      frame_tick <= 1'b1;
      lat <= 4'h1 + ($random(seed) & 4'h7);
      @(posedge ref_clk);
      frame_tick <= 1'b0;
      fr = fr + 1;
      for (i = 0; i < 80; i = i + 1) begin
        @(posedge ref_clk);
        #1 if (tx_req === 1'b1) begin
          got[tx_slot] = tx_value;
          at[tx_slot] = i;
          cnt[tx_slot] = cnt[tx_slot] + 1;
        end
      end
    end
  endtask
  task final_report;
    begin
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(7'h00, d); chk(d, 32'h3000);
    rd(7'h16, d); chk(d, 32'h1);
    rd(7'h5B, d); chk(d, 32'h0);
    // pulse slot: random increment and closures, change threshold one
    e = ($random(seed) & 32'hFF) | 32'h1;
    wr(7'h08, e); wr(7'h04, 32'h1); wr(7'h01, 32'h1); wr(7'h00, 32'h3001);
    j = ($random(seed) & 3) + 1;
    repeat (j) begin
      @(posedge ref_clk);
      tip_pulse <= 1'b1;
      @(posedge ref_clk);
      tip_pulse <= 1'b0;
    end
    d = j * e;
    tick; chk(got[0], d); chk(at[0], 3);
    tick; chk(cnt[0], 0);
    rd(7'h0C, p); chk(p, d);
    // periodic sends at offset one, then slot switched off before frame 11
    wr(7'h04, 32'h0); wr(7'h01, 32'h2); wr(7'h02, 32'h4); wr(7'h03, 32'h1);
    for (j = 0; j < 11; j = j + 1) begin
      if (j == 8) wr(7'h00, 32'h3000);
      tick; chk(cnt[0], (j < 8 && fr % 4 == 1) ? 1 : 0);
    end
    rd(7'h70, d); chk(d, fr);
    // both analogue inputs, current loop on the first, event mode always firing
    sl = $random(seed) & 32'hFFF;
    e = $random(seed);
    p = $random(seed);
    for (j = 1; j < 3; j = j + 1) begin
      wr({j[2:0], 4'h6}, sl); wr({j[2:0], 4'h7}, e); wr({j[2:0], 4'h8}, p);
      wr({j[2:0], 4'h5}, 32'h80000000); wr({j[2:0], 4'h1}, 32'h1);
      wr({j[2:0], 4'h0}, (j == 1) ? 32'h3007 : 32'h3003);
    end
    repeat (3) begin
      tick; chk(got[1], 32'h101*sl+e+p); chk(got[2], 32'h102*sl+e+p);
    end
    // sdi-12: slot three on bus a, slot four on bus b with r, command and address refusals
    wr(7'h3A, 32'h1); wr(7'h35, 32'h80000000); wr(7'h31, 32'h1); wr(7'h30, 32'h6103);
    wr(7'h45, 32'h80000000); wr(7'h41, 32'h1); wr(7'h40, 32'h5A0B); wr(7'h40, 32'h210B);
    rd(7'h40, d); chk(d[15:8], 32'h5A);
    wr(7'h49, 32'h352); wr(7'h49, 32'h353);
    rd(7'h49, d); chk(d, 32'h352);
    for (j = 0; j < 3; j = j + 1) begin
      wr(7'h39, j == 0 ? 32'h24D : j == 1 ? 32'h243 : 32'h252); if (j == 1) wr(7'h30, 32'h6113);
      tick; chk(got[3], 32'h6102); chk(got[4], 32'h5A03);
    end
    rd(7'h3A, d); chk(d, 32'h0);
    final_report;
  end
endmodule
